// *** lasr_pkg.sv ***
// Constants and carrier types for the lock and alarm status register block.
// Assumes a single 10 MHz clock; serial host pins arrive unsynchronised.
package lasr_pkg;

  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 8;
  localparam int          NUM_ALARM       = 5;
  localparam int          CNT_W           = 5;

  // Register addresses
  localparam logic [5:0]  ADDR_IRQ_ENABLE = 6'h00;
  localparam logic [5:0]  ADDR_CHANGE     = 6'h01;
  localparam logic [5:0]  ADDR_LIVE       = 6'h02;
  localparam logic [5:0]  ADDR_CONFIG0    = 6'h03;
  localparam logic [5:0]  ADDR_CONFIG1    = 6'h04;

  // Bit positions shared by enable, change and live registers; last two are config bits
  localparam int          BIT_OSC_LOCK    = 4;
  localparam int          BIT_SIGNAL_LOSS = 3;
  localparam int          BIT_RECOVERY    = 2;
  localparam int          BIT_MULTIPLIER  = 1;
  localparam int          BIT_OVERFLOW    = 0;
  localparam int          BIT_REF_FREQ    = 6;
  localparam int          BIT_OSC_DET_EN  = 0;

  // Reset values and reserved read bits
  localparam logic [7:0]  RST_CONFIG0     = 8'h40;
  localparam logic [7:0]  RST_CONFIG1     = 8'h00;
  localparam logic [4:0]  RST_ALARM       = 5'h00;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [15:0] RST_SHIFT       = 16'h0000;
  localparam logic [2:0]  RSVD_ZERO       = 3'h0;

  // Serial frame: one command bit, six address bits, dummy, eight data bits
  localparam logic [4:0]  CNT_ZERO        = 5'h00;
  localparam logic [4:0]  CNT_ONE         = 5'h01;
  localparam logic [4:0]  CNT_HDR_DONE    = 5'h08;
  localparam logic [4:0]  CNT_FRAME_DONE  = 5'h10;
  localparam int          SH_RW           = 8;
  localparam int          SH_ADDR_LO      = 9;
  localparam int          SH_ADDR_HI      = 14;
  localparam int          SH_DATA_LO      = 8;
  localparam int          SH_DATA_HI      = 15;

  // Alarm inputs, ordered D4 down to D0
  typedef struct packed {
    logic osc_lock;
    logic signal_loss;
    logic recovery_lock;
    logic multiplier_lock;
    logic overflow;
  } lasr_alarm_t;

  // Serial host pins
  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic sdi;
  } lasr_host_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_DATA = 2'b10,
    ST_HOLD = 2'b11
  } lasr_state_t;

endpackage

// *** lasr_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output moves when stages two and three agree.
module lasr_sync
  import lasr_pkg::*;
#(
  parameter int          WIDTH    = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_ff  <= RST_VAL;
      s2_ff  <= RST_VAL;
      s3_ff  <= RST_VAL;
      out_ff <= RST_VAL;
    end else begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;

endmodule

// *** lasr_top.sv ***
// Lock and alarm status registers behind the serial host interface.
// Assumes detector levels and host pins are asynchronous; SCLK well below clk/8.
// What this block does
// - Oscillator lock change sets flag D4
// - Signal loss change sets flag D3
// - Recovery lock change sets flag D2
// - Multiplier lock change sets flag D1
// - Overflow change sets flag D0
// - Interrupt only for enabled set flags
// - Oscillator bits void without detect enable
// - Live D4 shows oscillator lock
// - Live D3 shows signal loss
// - Live D2 shows recovery lock
// - Live D1 shows multiplier lock
// - Live D0 shows FIFO overflow
// - Config D6 selects reference, resets 1
// - Flag and live D7..D5 unused
// - Enable zero masks, one allows
module lasr_top
  import lasr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire lasr_host_t  host_in,
  input  wire lasr_alarm_t alarm_in,
  output logic             sdo,
  output logic             irq,
  output logic [7:0]       config0,
  output logic [7:0]       config1
);

  lasr_host_t  host_s;
  lasr_alarm_t alarm_s;

  lasr_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h4)
  ) u_host_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (host_in),
    .dout  (host_s)
  );

  lasr_sync #(
    .WIDTH   (NUM_ALARM),
    .RST_VAL (RST_ALARM)
  ) u_alarm_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (alarm_in),
    .dout  (alarm_s)
  );

  // Serial frame state
  lasr_state_t     state_ff;
  lasr_state_t     nxt_state;
  logic [4:0]      cnt_ff;
  logic [4:0]      nxt_cnt;
  logic [15:0]     sh_ff;
  logic [15:0]     nxt_sh;
  logic [15:0]     shift_in;
  logic            rw_ff;
  logic            nxt_rw;
  logic [5:0]      addr_ff;
  logic [5:0]      nxt_addr;
  logic [7:0]      rd_sh_ff;
  logic [7:0]      nxt_rd_sh;
  logic            sdo_ff;
  logic            nxt_sdo;
  logic            sclk_q_ff;
  logic            cs_q_ff;

  // Register state
  logic [4:0]      enable_ff;
  logic [4:0]      nxt_enable;
  logic [4:0]      flag_ff;
  logic [4:0]      nxt_flag;
  logic [4:0]      snap_ff;
  logic [4:0]      nxt_snap;
  logic [4:0]      prev_ff;
  logic [4:0]      live;
  logic [4:0]      event_v;
  logic [7:0]      cfg0_ff;
  logic [7:0]      nxt_cfg0;
  logic [7:0]      cfg1_ff;
  logic [7:0]      nxt_cfg1;
  logic            irq_ff;
  logic            nxt_irq;
  logic [7:0]      rd_data;

  logic            sclk_rise;
  logic            sclk_fall;
  logic            cs_rise;
  logic            frame_end;

  assign sclk_rise = host_s.sclk & ~sclk_q_ff;
  assign sclk_fall = ~host_s.sclk & sclk_q_ff;
  assign cs_rise   = host_s.cs_b & ~cs_q_ff;
  assign frame_end = cs_rise && (state_ff == ST_HOLD);
  assign shift_in  = {host_s.sdi, sh_ff[15:1]};

  // Live state, oscillator bit forced low without detect enable
  always_comb begin
    live                  = alarm_s;
    live[BIT_OSC_LOCK]    = alarm_s.osc_lock & cfg1_ff[BIT_OSC_DET_EN];
    event_v               = live ^ prev_ff;
    event_v[BIT_OSC_LOCK] = event_v[BIT_OSC_LOCK] & cfg1_ff[BIT_OSC_DET_EN];
  end

  // Read mux, unused upper bits read zero
  always_comb begin
    case (shift_in[SH_ADDR_HI:SH_ADDR_LO])
      ADDR_IRQ_ENABLE: rd_data = {RSVD_ZERO, enable_ff};
      ADDR_CHANGE:     rd_data = {RSVD_ZERO, flag_ff};
      ADDR_LIVE:       rd_data = {RSVD_ZERO, live};
      ADDR_CONFIG0:    rd_data = cfg0_ff;
      ADDR_CONFIG1:    rd_data = cfg1_ff;
      default:         rd_data = RST_BYTE;
    endcase
  end

  // Serial frame sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_rw    = rw_ff;
    nxt_addr  = addr_ff;
    nxt_rd_sh = rd_sh_ff;
    nxt_sdo   = sdo_ff;
    nxt_snap  = snap_ff;
    if (host_s.cs_b) begin
      nxt_state = ST_IDLE;
      nxt_cnt   = CNT_ZERO;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_HDR;
          nxt_cnt   = CNT_ZERO;
        end
        ST_HDR: begin
          if (sclk_rise) begin
            nxt_sh  = shift_in;
            nxt_cnt = cnt_ff + CNT_ONE;
            if (nxt_cnt == CNT_HDR_DONE) begin
              nxt_state = ST_DATA;
              nxt_rw    = nxt_sh[SH_RW];
              nxt_addr  = nxt_sh[SH_ADDR_HI:SH_ADDR_LO];
              nxt_rd_sh = rd_data;
              nxt_snap  = flag_ff;
            end
          end
        end
        ST_DATA: begin
          if (sclk_fall && rw_ff) begin
            nxt_sdo   = rd_sh_ff[0];
            nxt_rd_sh = {1'b0, rd_sh_ff[7:1]};
          end
          if (sclk_rise) begin
            nxt_sh  = shift_in;
            nxt_cnt = cnt_ff + CNT_ONE;
            if (nxt_cnt == CNT_FRAME_DONE) begin
              nxt_state = ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          nxt_state = ST_HOLD;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // Register updates, writes commit when chip select rises
  always_comb begin
    nxt_enable = enable_ff;
    nxt_cfg0   = cfg0_ff;
    nxt_cfg1   = cfg1_ff;
    nxt_flag   = flag_ff;
    if (frame_end && rw_ff && addr_ff == ADDR_CHANGE) begin
      nxt_flag = flag_ff & ~snap_ff;
    end
    if (frame_end && !rw_ff) begin
      case (addr_ff)
        ADDR_IRQ_ENABLE: nxt_enable = sh_ff[SH_DATA_LO+NUM_ALARM-1:SH_DATA_LO];
        ADDR_CONFIG0:    nxt_cfg0   = sh_ff[SH_DATA_HI:SH_DATA_LO];
        ADDR_CONFIG1:    nxt_cfg1   = sh_ff[SH_DATA_HI:SH_DATA_LO];
        default:         nxt_enable = enable_ff;
      endcase
    end
    nxt_flag = nxt_flag | event_v;
    nxt_irq  = |(nxt_flag & nxt_enable);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= CNT_ZERO;
      sh_ff     <= RST_SHIFT;
      rw_ff     <= 1'b0;
      addr_ff   <= ADDR_IRQ_ENABLE;
      rd_sh_ff  <= RST_BYTE;
      sdo_ff    <= 1'b0;
      sclk_q_ff <= 1'b0;
      cs_q_ff   <= 1'b1;
      snap_ff   <= RST_ALARM;
      enable_ff <= RST_ALARM;
      flag_ff   <= RST_ALARM;
      prev_ff   <= RST_ALARM;
      cfg0_ff   <= RST_CONFIG0;
      cfg1_ff   <= RST_CONFIG1;
      irq_ff    <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      sh_ff     <= nxt_sh;
      rw_ff     <= nxt_rw;
      addr_ff   <= nxt_addr;
      rd_sh_ff  <= nxt_rd_sh;
      sdo_ff    <= nxt_sdo;
      sclk_q_ff <= host_s.sclk;
      cs_q_ff   <= host_s.cs_b;
      snap_ff   <= nxt_snap;
      enable_ff <= nxt_enable;
      flag_ff   <= nxt_flag;
      prev_ff   <= live;
      cfg0_ff   <= nxt_cfg0;
      cfg1_ff   <= nxt_cfg1;
      irq_ff    <= nxt_irq;
    end
  end

  assign sdo     = sdo_ff;
  assign irq     = irq_ff;
  assign config0 = cfg0_ff;
  assign config1 = cfg1_ff;

endmodule

// *** lasr_top_properties.sv ***
// Port checker for the lock and alarm status register block.
// Assumes a bind onto lasr_top and the single clk domain.
module lasr_top_properties
  import lasr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire lasr_host_t  host_in,
  input wire lasr_alarm_t alarm_in,
  input wire logic        sdo,
  input wire logic        irq,
  input wire logic [7:0]  config0,
  input wire logic [7:0]  config1
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Frame open for a while
  sequence s_in_frame;
    !host_in.cs_b [*8];
  endsequence
  // No alarm movement inside a frame
  sequence s_quiet;
    ($stable(alarm_in) && !host_in.cs_b) [*8];
  endsequence
  // Serial clock and chip select idle
  sequence s_pins_still;
    ($stable(host_in.sclk) && $stable(host_in.cs_b)) [*8];
  endsequence

  chk_cfg0_reset: assert property ($rose(rst_b) |-> config0 == 8'h40)
    else $error("config0 not at reset value");
  chk_cfg1_reset: assert property ($rose(rst_b) |-> config1 == 8'h00)
    else $error("config1 not at reset value");
  chk_irq_reset: assert property ($rose(rst_b) |-> !irq)
    else $error("irq high after reset");
  chk_cfg0_hold: assert property (s_in_frame |=> $stable(config0))
    else $error("config0 moved inside a frame");
  chk_cfg1_hold: assert property (s_in_frame |=> $stable(config1))
    else $error("config1 moved inside a frame");
  chk_irq_no_clear: assert property (s_in_frame |=> !$fell(irq))
    else $error("irq fell inside a frame");
  chk_irq_no_cause: assert property (s_quiet |=> !$rose(irq))
    else $error("irq rose without an alarm change");
  chk_sdo_steady: assert property (s_pins_still |=> $stable(sdo))
    else $error("sdo moved with idle serial pins");
endmodule

bind lasr_top lasr_top_properties u_lasr_top_properties (
  .clk(clk), .rst_b(rst_b), .host_in(host_in), .alarm_in(alarm_in),
  .sdo(sdo), .irq(irq), .config0(config0), .config1(config1));

// *** test_lasr_top.sv ***
// Self-checking bench for lasr_top through serial host frames.
// Assumes 100 ns clock; inputs move on falling clk edges.
module test_lasr_top
  import lasr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk      = 1'b0;
  logic        rst_b    = 1'b0;
  lasr_host_t  host_in  = 3'h4;
  lasr_alarm_t alarm_in = 5'h00;
  logic        sdo;
  logic        irq;
  logic [7:0]  config0;
  logic [7:0]  config1;
  logic [7:0]  rd;
  logic [4:0]  prev;
  int          bad_count   = 0;
  int          checks_done = 0;

  always #50 clk = ~clk;

  lasr_top u_lasr_top (
    .clk(clk), .rst_b(rst_b), .host_in(host_in), .alarm_in(alarm_in),
    .sdo(sdo), .irq(irq), .config0(config0), .config1(config1));

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One 16-bit frame; read bits sampled before each later rise
  task automatic frame(input logic r, input logic [5:0] a, input logic [7:0] wd);
    logic [15:0] w;
    w = {wd, 1'b0, a, r};
    rd = 8'h00;
    host_in.cs_b = 1'b0;
    cyc(10);
    for (int b = 0; b < 16; b++) begin
      host_in.sdi = w[b];
      cyc(10);
      if (b >= 8) rd[b-8] = sdo;
      host_in.sclk = 1'b1;
      cyc(10);
      host_in.sclk = 1'b0;
    end
    cyc(10);
    host_in.cs_b = 1'b1;
    cyc(10);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    frame(1'b0, a, d);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
    frame(1'b1, a, 8'h00);
    chk(rd, exp);
  endtask

  task automatic final_report;
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end

  initial begin
    cyc(5);
    rst_b = 1'b1;
    cyc(2);
    chk(config0, 8'h40);
    rdc(ADDR_CONFIG0, 8'h40);
    rdc(ADDR_CHANGE, 8'h00);
    rdc(ADDR_LIVE, 8'h00);
    wr(ADDR_CONFIG1, 8'h01);
    chk(config1, 8'h01);
    rdc(ADDR_CONFIG1, 8'h01);
    prev = 5'h00;
    for (int i = 0; i < 5; i++) begin
      alarm_in = 5'h01 << i;
      cyc(12);
      rdc(ADDR_LIVE, {3'h0, 5'h01 << i});
      rdc(ADDR_CHANGE, {3'h0, prev ^ (5'h01 << i)});
      rdc(ADDR_CHANGE, 8'h00);
      prev = 5'h01 << i;
    end
    wr(ADDR_CONFIG1, 8'h00);
    chk(config1, 8'h00);
    rdc(ADDR_LIVE, 8'h00);
    alarm_in = 5'h00;
    cyc(12);
    rdc(ADDR_CHANGE, 8'h00);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    rdc(ADDR_IRQ_ENABLE, 8'h01);
    alarm_in = 5'h08;
    cyc(12);
    chk({7'h00, irq}, 8'h00);
    alarm_in = 5'h09;
    cyc(12);
    chk({7'h00, irq}, 8'h01);
    rdc(ADDR_CHANGE, 8'h09);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_CONFIG0, 8'h00);
    chk(config0, 8'h00);
    wr(ADDR_CONFIG0, 8'h40);
    rdc(ADDR_CONFIG0, 8'h40);
    wr(ADDR_LIVE, 8'hFF);
    rdc(ADDR_LIVE, 8'h09);
    rst_b = 1'b0;
    cyc(5);
    rst_b = 1'b1;
    cyc(2);
    chk(config0, 8'h40);
    chk({7'h00, irq}, 8'h00);
    final_report();
  end
endmodule
